//--- bench/ata_card_model.sv
// behavioural ata card: register store, read data, io-ready stalls
`timescale 1ns/1ps
module ata_card_model
    import ata_port_pkg::*;
(
    input wire logic clk,
    input wire card_ctl_t ctl,
    input wire logic [DATA_W-1:0] dout,
    input wire logic [DATA_W-1:0] oe,
    input wire logic [3:0] stall,
    output logic [DATA_W-1:0] din,
    output logic ready
);
    logic [DATA_W-1:0] mem [16];
    // the alternate select reaches its own register block
    wire [3:0] idx = {!ctl.cardSelectAlt_n, ctl.regAddr};
    logic rdPrev = 1'b1;
    logic wrPrev = 1'b1;
    logic [3:0] cnt = 4'h0;
    initial begin
        // each register starts with its own pattern, so a swapped select reads wrong
        foreach (mem[i]) mem[i] = 16'(i) * 16'h0101;
        din = '0;
    end
    assign ready = (cnt == 4'h0);
    always @(posedge clk) begin
        rdPrev <= ctl.cardReadStrobe_n;
        wrPrev <= ctl.cardWriteStrobe_n;
        // only driven lanes land, so a stray high-byte drive shows up later
        if (!ctl.cardWriteStrobe_n) mem[idx] <= (dout & oe) | (mem[idx] & ~oe);
        // released bus falls to its pull-down level
        din <= !ctl.cardReadStrobe_n ? mem[idx] : '0;
        if ((rdPrev && !ctl.cardReadStrobe_n) || (wrPrev && !ctl.cardWriteStrobe_n)) cnt <= stall;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
endmodule : ata_card_model

//--- bench/ata_port_properties.sv
// pin-level assertions for the ata task file host port
`timescale 1ns/1ps
module ata_port_properties
    import ata_port_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cardResetReq,
    input wire logic intrPending,
    input wire logic cardPresent,
    input wire card_ctl_t cardCtl,
    input wire logic [DATA_W-1:0] cardDataOe,
    input wire logic cardIntrReq,
    input wire logic cardIoReady,
    input wire logic cardDetectA_n,
    input wire logic cardDetectB_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic doneValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire rdLow = !cardCtl.cardReadStrobe_n;
    wire wrLow = !cardCtl.cardWriteStrobe_n;
    wire selIdle = cardCtl.cardSelectTaskfile_n && cardCtl.cardSelectAlt_n;
    wire [4:0] selAddr = {cardCtl.cardSelectTaskfile_n, cardCtl.cardSelectAlt_n, cardCtl.regAddr};
    // margins of four or five cycles cover the two-flop input synchronisers
    sequence readyLow; !cardIoReady [*4]; endsequence
    sequence strobeHeld; (rdLow || wrLow) ##1 (rdLow || wrLow); endsequence
    sequence doneEnd; selIdle ##1 !doneValid; endsequence
    chk_no_overlap: assert property (!(rdLow && wrLow))
        else $error("both strobes low");
    chk_one_select: assert property ((rdLow || wrLow) |-> !selIdle && (selAddr[4] ^ selAddr[3]))
        else $error("select not unique");
    chk_addr_stable: assert property (strobeHeld |-> $stable(selAddr))
        else $error("select or address moved");
    chk_ready_hold: assert property (readyLow ##0 (rdLow || wrLow) |=> rdLow || wrLow)
        else $error("strobe ended while not ready");
    chk_write_drive: assert property (wrLow |-> cardDataOe[7:0] == 8'hff)
        else $error("write data not driven");
    chk_read_float: assert property (rdLow |-> cardDataOe == 16'h0000)
        else $error("bus driven during read");
    chk_hw_reset: assert property (!$past(reset) |-> cardCtl.cardHwReset_n == !$past(cardResetReq))
        else $error("card reset wrong");
    chk_intr_level: assert property (cardIntrReq [*5] |-> intrPending)
        else $error("interrupt not pending");
    chk_card_present: assert property ((!cardDetectA_n && !cardDetectB_n) [*5] |-> cardPresent)
        else $error("card not present");
    chk_card_absent: assert property ((cardDetectA_n || cardDetectB_n) [*5] |-> !cardPresent)
        else $error("card wrongly present");
    chk_intr_clear: assert property (!cardIntrReq [*5] |-> !intrPending)
        else $error("interrupt pending without request");
    chk_take_select: assert property (reqValid && reqReady |=> !selIdle)
        else $error("request taken without a select");
    chk_done_release: assert property (doneValid |-> doneEnd)
        else $error("done without select release");
    chk_idle_strobes: assert property (reqReady |-> !rdLow && !wrLow)
        else $error("strobe low while idle");
endmodule : ata_port_properties

bind ata_task_file_host_port ata_port_properties chk (.clk(clk), .reset(reset),
    .cardResetReq(cardResetReq), .intrPending(intrPending), .cardPresent(cardPresent),
    .cardCtl(cardCtl), .cardDataOe(cardDataOe), .cardIntrReq(cardIntrReq),
    .cardIoReady(cardIoReady), .cardDetectA_n(cardDetectA_n), .cardDetectB_n(cardDetectB_n),
    .reqValid(reqValid), .reqReady(reqReady), .doneValid(doneValid));

//--- bench/ata_task_file_host_port_tb.sv
// self-checking bench for the ata task file host port
`timescale 1ns/1ps
module ata_task_file_host_port_tb
    import ata_port_pkg::*;
;
    logic clk = 0, reset = 1, reqValid = 0, cardResetReq = 0, cardIntrReq = 0;
    logic cardDetectA_n = 1, cardDetectB_n = 1;
    access_req_t req = '0;
    logic [3:0] stall = 4'h0;
    logic reqReady, doneValid, intrPending, cardPresent, cardIoReady;
    logic [DATA_W-1:0] rdata, cardDataOut, cardDataOe, cardDataIn;
    card_ctl_t cardCtl;
    logic [DATA_W-1:0] shadow [16];
    logic [16:0] notes [$];
    logic [31:0] seed = 32'h0000dab6;
    int nFail = 0, comparisons = 0;
    always #2 clk = ~clk;
    ata_task_file_host_port #(.SETUP_CYCLES(1), .STROBE_CYCLES(4), .RECOVER_CYCLES(1)) DUT (
        .clk(clk), .reset(reset), .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .doneValid(doneValid), .rdata(rdata), .cardResetReq(cardResetReq),
        .intrPending(intrPending), .cardPresent(cardPresent), .cardCtl(cardCtl),
        .cardDataIn(cardDataIn), .cardDataOut(cardDataOut), .cardDataOe(cardDataOe),
        .cardIntrReq(cardIntrReq), .cardIoReady(cardIoReady),
        .cardDetectA_n(cardDetectA_n), .cardDetectB_n(cardDetectB_n));
    ata_card_model card (.clk(clk), .ctl(cardCtl), .dout(cardDataOut), .oe(cardDataOe),
        .stall(stall), .din(cardDataIn), .ready(cardIoReady));
    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value rdata expected %h seen %h", exp, seen);
        end
    endtask : check
    task close_out;
        if (notes.size() != 0) nFail++;
        $display("comparisons %0d mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    // one note per access; writes carry no value to compare
    always @(negedge clk) begin : watch
        logic [16:0] n;
        if (doneValid === 1'b1) begin
            if (notes.size() == 0) begin
                nFail++;
            end else begin
                n = notes.pop_front();
                if (n[16]) check(rdata, n[15:0]);
            end
        end
    end
    task access(input logic [31:0] r);
        logic [3:0] a;
        a = {r[2], r[5:3]};
        notes.push_back({!r[0], r[1] ? shadow[a] : {8'h00, shadow[a][7:0]}});
        if (r[0]) shadow[a] = r[1] ? r[31:16] : {shadow[a][15:8], r[23:16]};
        @(posedge clk);
        req <= '{r[0], r[1], r[2], a[2:0], r[31:16]};
        reqValid <= 1'b1;
        // one-cycle request: held longer it would be taken again at idle
        @(posedge clk);
        reqValid <= 1'b0;
        for (int i = 0; i < 200 && doneValid !== 1'b1; i++) @(negedge clk);
        if (doneValid !== 1'b1) nFail++;
    endtask : access
    initial begin
        foreach (shadow[i]) shadow[i] = 16'(i) * 16'h0101;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (int k = 0; k < 60; k++) begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            @(posedge clk);
            stall <= {1'b0, seed[8:6]};
            cardIntrReq <= seed[9];
            cardDetectA_n <= seed[10];
            cardDetectB_n <= seed[10] | seed[11];
            cardResetReq <= seed[12];
            access(seed);
        end
        // let the watcher take the last result before the verdict
        repeat (2) @(posedge clk);
        close_out;
    end
    initial begin
        #16000;
        nFail++;
        close_out;
    end
endmodule : ata_task_file_host_port_tb

//--- logic/ata_port_pkg.sv
// shared constants and carrier types for the ata task file host port
package ata_port_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    // strobe timing, in ns as printed by our own choice, and cycles at 250 MHz
    localparam int CLK_PERIOD_NS = 4;
    localparam int SETUP_NS = 30;
    localparam int STROBE_NS = 120;
    localparam int RECOVER_NS = 60;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // reset values of the select and strobe pin outputs (all negated)
    localparam logic SEL_IDLE = 1'b1;
    localparam logic STROBE_IDLE = 1'b1;

    typedef enum {
        PH_IDLE,
        PH_SETUP,
        PH_STROBE,
        PH_WAIT_READY,
        PH_RECOVER
    } phase_t;

    // one access request from the controller side
    typedef struct packed {
        logic write;
        logic wide;
        logic altSelect;
        logic [ADDR_W-1:0] regAddr;
        logic [DATA_W-1:0] wdata;
    } access_req_t;

    // pins driven toward the card
    typedef struct packed {
        logic cardSelectTaskfile_n;
        logic cardSelectAlt_n;
        logic [ADDR_W-1:0] regAddr;
        logic cardReadStrobe_n;
        logic cardWriteStrobe_n;
        logic cardHwReset_n;
    } card_ctl_t;
endpackage : ata_port_pkg

//--- logic/ata_task_file_host_port.sv
// parallel host port that drives an ata card in direct ata mode
`timescale 1ns/1ps
module ata_task_file_host_port
    import ata_port_pkg::*;
#(
    parameter int SETUP_CYCLES = SETUP_CYC,
    parameter int STROBE_CYCLES = STROBE_CYC,
    parameter int RECOVER_CYCLES = RECOVER_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic reqValid,
    input wire access_req_t req,
    output logic reqReady,
    output logic doneValid,
    output logic [DATA_W-1:0] rdata,
    input wire logic cardResetReq,
    output logic intrPending,
    output logic cardPresent,
    output card_ctl_t cardCtl,
    input wire logic [DATA_W-1:0] cardDataIn,
    output logic [DATA_W-1:0] cardDataOut,
    output logic [DATA_W-1:0] cardDataOe,
    input wire logic cardIntrReq,
    input wire logic cardIoReady,
    input wire logic cardDetectA_n,
    input wire logic cardDetectB_n
);
    // counters hold cycles minus one, so a count of zero ends each phase
    localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYCLES - 1);
    localparam logic [CNT_W-1:0] RECOVER_LOAD = CNT_W'(RECOVER_CYCLES - 1);

    logic [3:0] pinsSync;
    logic ioReady;
    phase_t phase;
    logic [CNT_W-1:0] count;
    access_req_t cur;
    logic [DATA_W-1:0] dataSync;
    logic taking;
    logic strobeStart;
    logic strobeEnd;
    logic accessEnd;

    // pins from the card are asynchronous, so all pass two flops; reset
    // values follow the pull-ups and pull-downs on those pins
    pin_sync #(
        .WIDTH(4),
        .INIT(4'h7)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .din({cardIntrReq, cardIoReady, cardDetectB_n, cardDetectA_n}),
        .dout(pinsSync)
    );
    assign ioReady = pinsSync[2];
    // io ready lags two cycles, so the card must pull it low early in the strobe

    // the card holds the bus steady long before the strobe ends, so a per-bit
    // synchroniser cannot tear the word; the cost is two cycles of latency
    pin_sync #(
        .WIDTH(DATA_W),
        .INIT('0)
    ) u_data_sync (
        .clk(clk),
        .reset(reset),
        .din(cardDataIn),
        .dout(dataSync)
    );

    // one name per event keeps sequencer, pins and data bus in step
    assign taking = (phase == PH_IDLE) && reqValid;
    assign strobeStart = (phase == PH_SETUP) && (count == '0);
    assign strobeEnd = ((phase == PH_STROBE) && (count == '0) && ioReady)
                       || ((phase == PH_WAIT_READY) && ioReady);
    assign accessEnd = (phase == PH_RECOVER) && (count == '0);

    // status outputs from the synchronised pins
    always_ff @(posedge clk) begin
        if (reset) begin
            intrPending <= 1'b0;
            cardPresent <= 1'b0;
        end else begin
            intrPending <= pinsSync[3];
            // a half-seated card grounds only one detect and stays absent
            cardPresent <= ~pinsSync[0] & ~pinsSync[1];
        end
    end

    // access sequencer
    // one access at a time; reqValid outside idle is ignored, not queued
    always_ff @(posedge clk) begin
        if (reset) begin
            phase <= PH_IDLE;
            count <= '0;
            cur <= '0;
        end else begin
            case (phase)
                PH_IDLE: begin
                    if (reqValid) begin
                        cur <= req;
                        count <= SETUP_LOAD;
                        phase <= PH_SETUP;
                    end
                end
                PH_SETUP: begin
                    if (count == '0) begin
                        count <= STROBE_LOAD;
                        phase <= PH_STROBE;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                PH_STROBE: begin
                    if (count != '0) begin
                        count <= count - 1'b1;
                    end else if (ioReady) begin
                        count <= RECOVER_LOAD;
                        phase <= PH_RECOVER;
                    end else begin
                        phase <= PH_WAIT_READY;
                    end
                end
                PH_WAIT_READY: begin
                    // no time limit: a card that never raises io ready stalls the port
                    if (ioReady) begin
                        count <= RECOVER_LOAD;
                        phase <= PH_RECOVER;
                    end
                end
                PH_RECOVER: begin
                    // selects and write data stay put here as hold time
                    if (count == '0) begin
                        phase <= PH_IDLE;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end

    // pin outputs; selects and address load from req only on the taking edge, so they
    // cannot move while a strobe is low
    always_ff @(posedge clk) begin
        if (reset) begin
            cardCtl.cardSelectTaskfile_n <= SEL_IDLE;
            cardCtl.cardSelectAlt_n <= SEL_IDLE;
            cardCtl.regAddr <= '0;
            cardCtl.cardReadStrobe_n <= STROBE_IDLE;
            cardCtl.cardWriteStrobe_n <= STROBE_IDLE;
            // the card is held in reset with the port, so it starts clean
            cardCtl.cardHwReset_n <= 1'b0;
        end else begin
            cardCtl.cardHwReset_n <= ~cardResetReq;
            if (taking) begin
                cardCtl.cardSelectTaskfile_n <= req.altSelect;
                cardCtl.cardSelectAlt_n <= ~req.altSelect;
                cardCtl.regAddr <= req.regAddr;
            end else if (accessEnd) begin
                cardCtl.cardSelectTaskfile_n <= SEL_IDLE;
                cardCtl.cardSelectAlt_n <= SEL_IDLE;
            end
            // only one strobe can be low, chosen by a single write bit
            if (strobeStart) begin
                cardCtl.cardReadStrobe_n <= cur.write;
                cardCtl.cardWriteStrobe_n <= ~cur.write;
            end else if (strobeEnd) begin
                cardCtl.cardReadStrobe_n <= STROBE_IDLE;
                cardCtl.cardWriteStrobe_n <= STROBE_IDLE;
            end
        end
    end

    // data bus drive and capture
    always_ff @(posedge clk) begin
        if (reset) begin
            cardDataOut <= '0;
            cardDataOe <= '0;
            rdata <= '0;
        end else begin
            if (strobeStart && cur.write) begin
                cardDataOut <= cur.wide ? cur.wdata : {8'h00, cur.wdata[7:0]};
                cardDataOe <= cur.wide ? 16'hffff : 16'h00ff;
            end else if (phase == PH_IDLE) begin
                cardDataOe <= '0;
            end
            // read data sampled at the edge that raises the strobe
            if (!cur.write && strobeEnd) begin
                rdata <= cur.wide ? dataSync : {8'h00, dataSync[7:0]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reqReady <= 1'b0;
            doneValid <= 1'b0;
        end else begin
            // informational only: it drops on the edge that sees a request
            reqReady <= (phase == PH_IDLE) && !reqValid;
            doneValid <= accessEnd;
        end
    end
endmodule : ata_task_file_host_port

//--- logic/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage;

    // first stage feeds only the second one
    always_ff @(posedge clk) begin
        if (reset) begin
            stage <= INIT;
            dout <= INIT;
        end else begin
            stage <= din;
            dout <= stage;
        end
    end
endmodule : pin_sync
